/* File: dv/pwm_channel_props.sv */
// Concurrent checks on the ports of the pwm channel.
// Assumes one clock domain and a bind from the bench top file.
module pwm_channel_props (
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_i,
   // Observed ports
   input wire logic        count_start_flag_i,
   input wire logic [1:0]  trig_sel_i,
   input wire logic        trigger_input_pin_i,
   input wire logic        tb2_flow_i,
   input wire logic        prev_flow_i,
   input wire logic        next_flow_i,
   input wire logic [15:0] setting_rdata_o,
   input wire logic        pulse_output_pin_o,
   input wire logic        irq_o,
   input wire logic        running_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Pin edge needs sync and detect, so six quiet samples are safe
   sequence pin_quiet;
      $stable(trigger_input_pin_i) [*6];
   endsequence
   sequence ext_armed;
      trig_sel_i == 2'h1 && !running_o;
   endsequence

   a_irq_on_fall: assert property ($fell(pulse_output_pin_o) |-> irq_o)
      else $error("irq missing at pulse fall");
   a_irq_has_cause: assert property (irq_o |-> $fell(pulse_output_pin_o))
      else $error("irq without pulse fall");
   a_irq_one_cycle: assert property (irq_o |=> !irq_o)
      else $error("irq longer than one cycle");
   a_low_when_idle: assert property (!running_o |-> !pulse_output_pin_o)
      else $error("pulse high while not running");
   a_stop_halts: assert property (!count_start_flag_i |=> !running_o)
      else $error("running after start flag cleared");
   a_start_plain: assert property
      (trig_sel_i == 2'h0 && count_start_flag_i && !running_o |=> running_o)
      else $error("no start without trigger");
   a_run_holds: assert property (running_o && count_start_flag_i |=> running_o)
      else $error("run disturbed while flag set");
   a_ext_waits: assert property (pin_quiet ##0 ext_armed |=> !running_o)
      else $error("start without pin edge");
   a_int_waits: assert property (trig_sel_i == 2'h2 && !running_o && !tb2_flow_i
      && !prev_flow_i && !next_flow_i |=> !running_o)
      else $error("start without overflow strobe");
   a_read_fill: assert property (setting_rdata_o == 16'h0000)
      else $error("read data not fill value");
endmodule : pwm_channel_props

/* File: dv/pwm_load.sv */
// Load on the pulse output pin: measures high width and period in clocks.
// Assumes the pin is sampled on the rising edge of the channel clock.
module pwm_load (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Pin
   input  wire logic        pulse_i,
   // Measurements
   output logic      [31:0] high_o,
   output logic      [31:0] period_o,
   output logic      [31:0] falls_o,
   output logic      [31:0] rises_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] hcnt_q;
   logic [31:0] pcnt_q;
   logic        prev_q;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         {hcnt_q, pcnt_q, prev_q, high_o, period_o, falls_o, rises_o} <= '0;
      end else begin
         prev_q <= pulse_i;
         hcnt_q <= pulse_i ? hcnt_q + 32'h1 : 32'h0;
         pcnt_q <= (pulse_i && !prev_q) ? 32'h1 : pcnt_q + 32'h1;
         if (pulse_i && !prev_q) begin
            period_o <= pcnt_q;
            rises_o  <= rises_o + 32'h1;
         end
         if (!pulse_i && prev_q) begin
            high_o  <= hcnt_q;
            falls_o <= falls_o + 32'h1;
         end
      end
   end
endmodule : pwm_load

/* File: dv/timer_pwm_mode_channel_test.sv */
// Bench for the pwm channel: control sequences checked against pin widths.
// Assumes the load model measures in clock cycles of clock_i.
`include "pwm_channel_map.svh"
module timer_pwm_mode_channel_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        count_start_flag_i = 1'b0;
   logic        mode_16bit_i = 1'b0;
   logic [2:0]  clk_sel_i = 3'h0;
   logic [1:0]  trig_sel_i = 2'h0;
   logic        trig_falling_i = 1'b0;
   logic        setting_wr_i = 1'b0;
   logic [15:0] setting_wdata_i = 16'h0000;
   logic        subclk_i = 1'b0;
   logic        trigger_input_pin_i = 1'b0;
   logic        tb2_flow_i = 1'b0;
   logic        prev_flow_i = 1'b0;
   logic        next_flow_i = 1'b0;
   logic [15:0] setting_rdata_o;
   logic        pulse_output_pin_o;
   logic        irq_o;
   logic        running_o;
   logic [31:0] high;
   logic [31:0] period;
   logic [31:0] falls;
   logic [31:0] rises;
   logic [31:0] rises_seen;
   int          error_cnt = 0;
   int          num_checks = 0;
   logic [2:0]  sels [5] = '{`CLK_SEL_DIV1, `CLK_SEL_DIV2, `CLK_SEL_DIV8, `CLK_SEL_DIV32,
                             `CLK_SEL_SUB32};
   logic [31:0] highs [5] = '{32'h2, 32'h4, 32'h10, 32'h40, 32'h80};

   always #2 clock_i = ~clock_i;
   // Sub clock edges land on falling edges of the system clock
   always #4 subclk_i = ~subclk_i;

   pwm_channel uut (.clock_i(clock_i), .rst_i(rst_i), .count_start_flag_i(count_start_flag_i),
      .mode_16bit_i(mode_16bit_i), .clk_sel_i(clk_sel_i), .trig_sel_i(trig_sel_i),
      .trig_falling_i(trig_falling_i), .setting_wr_i(setting_wr_i),
      .setting_wdata_i(setting_wdata_i), .setting_rdata_o(setting_rdata_o),
      .subclk_i(subclk_i), .trigger_input_pin_i(trigger_input_pin_i),
      .tb2_flow_i(tb2_flow_i), .prev_flow_i(prev_flow_i), .next_flow_i(next_flow_i),
      .pulse_output_pin_o(pulse_output_pin_o), .irq_o(irq_o), .running_o(running_o));
   pwm_load load_i (.clock_i(clock_i), .rst_i(rst_i), .pulse_i(pulse_output_pin_o),
      .high_o(high), .period_o(period), .falls_o(falls), .rises_o(rises));

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : check

   task automatic write_setting(input logic [15:0] val);
      setting_wr_i = 1'b1;
      setting_wdata_i = val;
      tick(1);
      setting_wr_i = 1'b0;
   endtask : write_setting

   task automatic wait_falls(input logic [31:0] k);
      logic [31:0] target;
      target = falls + k;
      for (int i = 0; i < 40000 && falls !== target; i++) tick(1);
      check("fall count", target, falls);
      if (falls !== target) finish_test();
   endtask : wait_falls

   // Written while stopped, so the counter loads too
   task automatic run(input logic [2:0] sel, input logic m16, input logic [15:0] val);
      count_start_flag_i = 1'b0;
      tick(2);
      clk_sel_i = sel;
      mode_16bit_i = m16;
      write_setting(val);
      count_start_flag_i = 1'b1;
      tick(1);
   endtask : run

   initial begin
      tick(2);
      rst_i = 1'b0;
      check("pulse after reset", 32'h0, pulse_output_pin_o);
      check("read data", 32'h0, setting_rdata_o);
      $display("test reset done");
      run(`CLK_SEL_DIV1, 1'b0, 16'h0301);
      check("running", 32'h1, running_o);
      wait_falls(3);
      check("high 8-bit", 32'h6, high);
      check("period 8-bit", 32'h1FE, period);
      write_setting(16'h0501);
      wait_falls(2);
      check("high after write", 32'hA, high);
      check("period after write", 32'h1FE, period);
      count_start_flag_i = 1'b0;
      tick(2);
      check("running stopped", 32'h0, running_o);
      rises_seen = rises;
      tick(600);
      check("rises when stopped", rises_seen, rises);
      $display("test 8-bit done");
      foreach (sels[i]) begin
         run(sels[i], 1'b0, 16'h0200);
         wait_falls(2);
         check("high per source", highs[i], high);
      end
      $display("test sources done");
      run(`CLK_SEL_DIV1, 1'b1, 16'h0005);
      wait_falls(1);
      check("high 16-bit", 32'h5, high);
      $display("test 16-bit done");
      trig_sel_i = `TRIG_SEL_EXT;
      run(`CLK_SEL_DIV1, 1'b0, 16'h0300);
      tick(20);
      check("ext armed", 32'h0, running_o);
      trigger_input_pin_i = 1'b1;
      tick(6);
      check("ext start", 32'h1, running_o);
      for (int t = 0; t < 4; t++) begin
         tick(50);
         trigger_input_pin_i = ~trigger_input_pin_i;
      end
      wait_falls(2);
      check("period with triggers", 32'hFF, period);
      // Falling pin edge selected; pin idles high here
      trig_falling_i = 1'b1;
      run(`CLK_SEL_DIV1, 1'b0, 16'h0300);
      tick(20);
      check("falling armed", 32'h0, running_o);
      trigger_input_pin_i = 1'b0;
      tick(6);
      check("falling start", 32'h1, running_o);
      trig_falling_i = 1'b0;
      $display("test external trigger done");
      trig_sel_i = `TRIG_SEL_INT;
      for (int k = 0; k < 3; k++) begin
         run(`CLK_SEL_DIV1, 1'b0, 16'h0300);
         tick(5);
         check("int armed", 32'h0, running_o);
         {tb2_flow_i, prev_flow_i, next_flow_i} = 3'h4 >> k;
         tick(1);
         {tb2_flow_i, prev_flow_i, next_flow_i} = 3'h0;
         tick(1);
         check("int start", 32'h1, running_o);
      end
      $display("test internal trigger done");
      // Reset in mid-run drops the channel to idle
      rst_i = 1'b1;
      tick(2);
      rst_i = 1'b0;
      check("pulse after second reset", 32'h0, pulse_output_pin_o);
      check("running after second reset", 32'h0, running_o);
      $display("test second reset done");
      finish_test();
   end
endmodule : timer_pwm_mode_channel_test

bind pwm_channel pwm_channel_props props_i (.clock_i(clock_i), .rst_i(rst_i),
   .count_start_flag_i(count_start_flag_i), .trig_sel_i(trig_sel_i),
   .trigger_input_pin_i(trigger_input_pin_i), .tb2_flow_i(tb2_flow_i),
   .prev_flow_i(prev_flow_i), .next_flow_i(next_flow_i), .setting_rdata_o(setting_rdata_o),
   .pulse_output_pin_o(pulse_output_pin_o), .irq_o(irq_o), .running_o(running_o));

/* File: logic/pwm_channel.sv */
// One timer channel in pulse width modulation mode, 16-bit or 8-bit.
// Assumes control inputs and neighbour overflow strobes come from logic on
// clock_i; the sub clock and trigger pin are asynchronous and synchronised.
//
// Behaviour
// - Count source: system clock divided by 1, 2, 8, 32, or sub clock by 32.
// - Counter counts down, as an 8-bit or a 16-bit modulator.
// - Each pulse rising edge reloads the setting and counting continues.
// - Triggers arriving while running are ignored.
// - 16-bit: high phase lasts n count-source periods.
// - 16-bit: period fixed at 65535 count-source periods.
// - 8-bit: high phase lasts n times (m+1) periods, n the high byte.
// - 8-bit: period is 255 times (m+1) periods, m the low byte.
// - No trigger selected: start as soon as start flag is set.
// - External trigger: start on flag set and active pin edge.
// - Internal trigger: start on timer B2 or neighbour overflow strobe.
// - Clearing the start flag stops counting and pulse generation.
// - Interrupt request at each falling edge of the pulse.
// - Output pin carries the pulse; input pin serves as trigger.
// - Reads of the setting register return an undefined value.
// - Write while stopped or before first tick loads reload and counter.
// - Write after first tick loads only the reload register.
// - New written width reaches the counter at the next reload.
`include "pwm_channel_map.svh"

module pwm_channel (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Control bits
   input  wire logic        count_start_flag_i,
   input  wire logic        mode_16bit_i,
   input  wire logic [2:0]  clk_sel_i,
   input  wire logic [1:0]  trig_sel_i,
   input  wire logic        trig_falling_i,
   // Setting register access
   input  wire logic        setting_wr_i,
   input  wire logic [15:0] setting_wdata_i,
   output logic      [15:0] setting_rdata_o,
   // Count source and triggers
   input  wire logic        subclk_i,
   input  wire logic        trigger_input_pin_i,
   input  wire logic        tb2_flow_i,
   input  wire logic        prev_flow_i,
   input  wire logic        next_flow_i,
   // Outputs
   output logic             pulse_output_pin_o,
   output logic             irq_o,
   output logic             running_o
);

   pwm_channel_pkg::chan_regs_t r_q;
   pwm_channel_pkg::chan_regs_t r_d;

   // High-phase step count from a setting value
   function automatic logic [15:0] high_of(input logic m16, input logic [15:0] v);
      high_of = m16 ? v : {8'h00, v[15:8]};
   endfunction : high_of

   // Prescaler reload from a setting value; 16-bit mode has none
   function automatic logic [7:0] pre_of(input logic m16, input logic [15:0] v);
      pre_of = m16 ? `RESET_BYTE : v[7:0];
   endfunction : pre_of

   // Period in modulator steps for the current width
   function automatic logic [15:0] period_of(input logic m16);
      period_of = m16 ? `PERIOD_16 : `PERIOD_8;
   endfunction : period_of

   logic        tick;
   logic        step;
   logic        sub_rise;
   logic        pin_edge;
   logic        trig_hit;
   logic [15:0] new_high;
   logic        reload_now;

   always_comb begin
      r_d = r_q;
      tick = 1'b0;
      step = 1'b0;
      sub_rise = 1'b0;
      pin_edge = 1'b0;
      trig_hit = 1'b0;
      new_high = high_of(mode_16bit_i, r_q.reload);
      reload_now = 1'b0;

      // Synchronisers; only the second stage feeds logic
      r_d.sub_sync = {r_q.sub_sync[0], subclk_i};
      r_d.sub_prev = r_q.sub_sync[1];
      r_d.trig_sync = {r_q.trig_sync[0], trigger_input_pin_i};
      r_d.trig_prev = r_q.trig_sync[1];
      sub_rise = r_q.sub_sync[1] & ~r_q.sub_prev;

      pin_edge = trig_falling_i ? (r_q.trig_prev & ~r_q.trig_sync[1])
                                : (r_q.trig_sync[1] & ~r_q.trig_prev);

      r_d.div_cnt = r_q.div_cnt + `DIV_ONE;
      if (sub_rise) begin
         r_d.sub_cnt = r_q.sub_cnt + `DIV_ONE;
      end
      case (clk_sel_i)
         `CLK_SEL_DIV1: begin
            tick = 1'b1;
         end
         `CLK_SEL_DIV2: begin
            tick = (r_q.div_cnt & `DIV_MASK_2) == `DIV_MASK_2;
         end
         `CLK_SEL_DIV8: begin
            tick = (r_q.div_cnt & `DIV_MASK_8) == `DIV_MASK_8;
         end
         `CLK_SEL_DIV32: begin
            tick = (r_q.div_cnt & `DIV_MASK_32) == `DIV_MASK_32;
         end
         `CLK_SEL_SUB32: begin
            tick = sub_rise && (r_q.sub_cnt == `DIV_MASK_32);
         end
         default: begin
            tick = 1'b0;
         end
      endcase

      // Trigger selection
      case (trig_sel_i)
         `TRIG_SEL_EXT: begin
            trig_hit = pin_edge;
         end
         `TRIG_SEL_INT: begin
            trig_hit = tb2_flow_i | prev_flow_i | next_flow_i;
         end
         default: begin
            trig_hit = 1'b0;
         end
      endcase

      // Read gives a fixed filler, never the live count
      r_d.read_data = `READ_FILL;
      r_d.irq = 1'b0;

      case (r_q.st)
         pwm_channel_pkg::ST_IDLE: begin
            r_d.pulse = 1'b0;
            r_d.seen = 1'b0;
            r_d.running = 1'b0;
            if (count_start_flag_i) begin
               if (trig_sel_i == `TRIG_SEL_NONE) begin
                  r_d.st = pwm_channel_pkg::ST_RUN;
                  r_d.running = 1'b1;
                  r_d.pulse = new_high != `RESET_WORD;
                  r_d.high_cnt = new_high;
                  r_d.per_cnt = period_of(mode_16bit_i);
                  r_d.pre_cnt = pre_of(mode_16bit_i, r_q.reload);
               end else begin
                  r_d.st = pwm_channel_pkg::ST_ARMED;
               end
            end
         end
         pwm_channel_pkg::ST_ARMED: begin
            r_d.pulse = 1'b0;
            r_d.seen = 1'b0;
            if (!count_start_flag_i) begin
               r_d.st = pwm_channel_pkg::ST_IDLE;
            end else if (trig_hit) begin
               r_d.st = pwm_channel_pkg::ST_RUN;
               r_d.running = 1'b1;
               r_d.pulse = new_high != `RESET_WORD;
               r_d.high_cnt = new_high;
               r_d.per_cnt = period_of(mode_16bit_i);
               r_d.pre_cnt = pre_of(mode_16bit_i, r_q.reload);
            end
         end
         pwm_channel_pkg::ST_RUN: begin
            // Triggers are not looked at here
            if (!count_start_flag_i) begin
               r_d.st = pwm_channel_pkg::ST_IDLE;
               r_d.running = 1'b0;
               r_d.pulse = 1'b0;
               r_d.seen = 1'b0;
            end else if (tick) begin
               r_d.seen = 1'b1;
               // Prescaler stretches each step by m+1 ticks
               if (mode_16bit_i || r_q.pre_cnt == `RESET_BYTE) begin
                  step = 1'b1;
                  r_d.pre_cnt = pre_of(mode_16bit_i, r_q.reload);
               end else begin
                  r_d.pre_cnt = r_q.pre_cnt - `BYTE_ONE;
               end
            end
            if (count_start_flag_i && step) begin
               if (r_q.high_cnt != `RESET_WORD) begin
                  r_d.high_cnt = r_q.high_cnt - `COUNT_ONE;
               end
               // Output falls when the high count expires
               if (r_q.high_cnt == `COUNT_ONE) begin
                  r_d.pulse = 1'b0;
               end
               // Fixed period, 2^16-1 or 2^8-1 steps
               r_d.per_cnt = r_q.per_cnt - `COUNT_ONE;
               reload_now = r_q.per_cnt == `COUNT_ONE;
            end
            if (reload_now) begin
               // Rising edge reloads and counting carries on
               // Period restarts in the current width
               r_d.per_cnt = period_of(mode_16bit_i);
               r_d.high_cnt = new_high;
               r_d.pulse = new_high != `RESET_WORD;
            end
         end
         default: begin
            r_d.st = pwm_channel_pkg::ST_IDLE;
            r_d.pulse = 1'b0;
            r_d.running = 1'b0;
            r_d.seen = 1'b0;
         end
      endcase

      // Setting register write
      if (setting_wr_i) begin
         r_d.reload = setting_wdata_i;
         // Before the first tick the counter follows the write
         if (r_q.st != pwm_channel_pkg::ST_RUN || !r_q.seen) begin
            r_d.high_cnt = high_of(mode_16bit_i, setting_wdata_i);
            r_d.pre_cnt = pre_of(mode_16bit_i, setting_wdata_i);
            if (r_q.st == pwm_channel_pkg::ST_RUN) begin
               r_d.pulse = high_of(mode_16bit_i, setting_wdata_i) != `RESET_WORD;
            end
         end
         // After the first tick only the reload register changes
      end

      r_d.irq = r_q.pulse & ~r_d.pulse;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         r_q.st <= pwm_channel_pkg::ST_IDLE;
         r_q.div_cnt <= `DIV_ZERO;
         r_q.sub_sync <= 2'h0;
         r_q.sub_prev <= 1'b0;
         r_q.sub_cnt <= `DIV_ZERO;
         r_q.trig_sync <= 2'h0;
         r_q.trig_prev <= 1'b0;
         r_q.reload <= `RESET_WORD;
         r_q.high_cnt <= `RESET_WORD;
         r_q.per_cnt <= `RESET_WORD;
         r_q.pre_cnt <= `RESET_BYTE;
         r_q.seen <= 1'b0;
         r_q.pulse <= 1'b0;
         r_q.irq <= 1'b0;
         r_q.running <= 1'b0;
         r_q.read_data <= `READ_FILL;
      end else begin
         r_q <= r_d;
      end
   end

   assign pulse_output_pin_o = r_q.pulse;
   assign irq_o = r_q.irq;
   assign running_o = r_q.running;
   assign setting_rdata_o = r_q.read_data;

endmodule : pwm_channel

/* File: logic/pwm_channel_map.svh */
// Constants for the pulse width modulation timer channel.
// Assumes inclusion by bare name from the package and the channel module.
`ifndef PWM_CHANNEL_MAP_SVH
`define PWM_CHANNEL_MAP_SVH

// Count source select codes
`define CLK_SEL_DIV1      3'h0
`define CLK_SEL_DIV2      3'h1
`define CLK_SEL_DIV8      3'h2
`define CLK_SEL_DIV32     3'h3
`define CLK_SEL_SUB32     3'h4

// Divider masks: a tick fires when all masked bits are set
`define DIV_MASK_2        5'h01
`define DIV_MASK_8        5'h07
`define DIV_MASK_32       5'h1F
`define DIV_ZERO          5'h00
`define DIV_ONE           5'h01

// Trigger select codes
`define TRIG_SEL_NONE     2'h0
`define TRIG_SEL_EXT      2'h1
`define TRIG_SEL_INT      2'h2

// Periods in modulator steps, 2^16-1 and 2^8-1
`define PERIOD_16         16'hFFFF
`define PERIOD_8          16'h00FF

// Reset values and small counts
`define RESET_WORD        16'h0000
`define RESET_BYTE        8'h00
`define COUNT_ONE         16'h0001
`define BYTE_ONE          8'h01

// Value returned by a read of the setting register; arbitrary
`define READ_FILL         16'h0000

`endif

/* File: logic/pwm_channel_pkg.sv */
// Types for the pulse width modulation timer channel.
// Assumes the constants header is on the include path.
`include "pwm_channel_map.svh"

package pwm_channel_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_ARMED = 3'h2,
      ST_RUN   = 3'h4
   } chan_state_t;

   typedef struct packed {
      chan_state_t st;
      logic [4:0]  div_cnt;
      logic [1:0]  sub_sync;
      logic        sub_prev;
      logic [4:0]  sub_cnt;
      logic [1:0]  trig_sync;
      logic        trig_prev;
      logic [15:0] reload;
      logic [15:0] high_cnt;
      logic [15:0] per_cnt;
      logic [7:0]  pre_cnt;
      logic        seen;
      logic        pulse;
      logic        irq;
      logic        running;
      logic [15:0] read_data;
   } chan_regs_t;

endpackage : pwm_channel_pkg
